// ===== hdl/gtimer_pkg.sv
// Purpose: constants for the gated sixteen-bit timer
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
package gtimer_pkg;
  localparam logic [7:0] TIMER_CONTROL_OFS = 8'h00;
  localparam logic [7:0] GATE_CONTROL_OFS = 8'h04;
  localparam logic [7:0] GATE_SOURCE_OFS = 8'h08;
  localparam logic [7:0] CLOCK_SOURCE_OFS = 8'h0c;
  localparam logic [7:0] COUNT_LOW_OFS = 8'h10;
  localparam logic [7:0] COUNT_HIGH_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  // register indices returned by the decoder
  localparam logic [3:0] IDX_TCTRL = 4'h0;
  localparam logic [3:0] IDX_GCTRL = 4'h1;
  localparam logic [3:0] IDX_GSRC = 4'h2;
  localparam logic [3:0] IDX_CSRC = 4'h3;
  localparam logic [3:0] IDX_CLOW = 4'h4;
  localparam logic [3:0] IDX_CHIGH = 4'h5;
  localparam logic [3:0] IDX_STAT = 4'h6;
  localparam logic [3:0] IDX_NONE = 4'hf;
  // timer_control fields
  localparam int TIMER_ON_BIT = 0;
  localparam int UNSYNC_BIT = 2;
  localparam int PRESCALE_LSB = 4;
  // gate_control fields
  localparam int GATE_ENABLE_BIT = 7;
  localparam int GATE_POLARITY_BIT = 6;
  localparam int GATE_VALUE_BIT = 2;
  // gate_source_select fields
  localparam int CMP1_SYNC_BIT = 4;
  localparam int CMP2_SYNC_BIT = 5;
  localparam logic [2:0] GSRC_PIN = 3'h0;
  localparam logic [2:0] GSRC_T0 = 3'h1;
  localparam logic [2:0] GSRC_CMP1 = 3'h2;
  localparam logic [2:0] GSRC_CMP2 = 3'h3;
  // clock_source_select codes
  localparam logic [1:0] CSRC_INSTR = 2'h0;
  localparam logic [1:0] CSRC_FULL = 2'h1;
  localparam logic [1:0] CSRC_EXT = 2'h2;
  // status fields
  localparam int OVF_BIT = 0;
  // reset values
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] GCTRL_RST = 8'h00;
  localparam logic [7:0] GSRC_RST = 8'h00;
  localparam logic [1:0] CSRC_RST = 2'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // instruction cycle is four system clocks
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gtimer_pkg

// ===== hdl/gated_sixteen_bit_timer.sv
// Purpose: gated 16-bit timer/counter with prescaler and AXI4-Lite registers
// Assumes: all inputs synchronous to CLK; timer0 and comparator signals come from other blocks
// Notes: one clock domain; the unsynchronised path samples the raw input once
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module gated_sixteen_bit_timer (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // axi4-lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  // axi4-lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // axi4-lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // axi4-lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // count and gate sources
  input wire logic EXT_COUNT_IN,
  input wire logic GATE_PIN_IN,
  input wire logic T0_OVERFLOW,
  input wire logic T0_PERIOD_MATCH,
  input wire logic T0_MODE_8BIT,
  input wire logic CMP1_OUT,
  input wire logic CMP2_OUT,
  // power state
  input wire logic SLEEP,
  // results
  output logic OVERFLOW_FLAG,
  output logic WAKE_REQ,
  output logic [15:0] COUNT_VALUE
);
  import gtimer_pkg::*;

  // exact byte-address match; any other address is unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    case (addr)
      TIMER_CONTROL_OFS: reg_index = IDX_TCTRL;
      GATE_CONTROL_OFS: reg_index = IDX_GCTRL;
      GATE_SOURCE_OFS: reg_index = IDX_GSRC;
      CLOCK_SOURCE_OFS: reg_index = IDX_CSRC;
      COUNT_LOW_OFS: reg_index = IDX_CLOW;
      COUNT_HIGH_OFS: reg_index = IDX_CHIGH;
      STATUS_OFS: reg_index = IDX_STAT;
      default: reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  // bus state
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_take, w_take, ar_take, do_write;
  logic aw_have_nxt, w_have_nxt, bvalid_nxt, rvalid_nxt;
  logic [3:0] wr_idx, rd_idx;
  logic wr_b0;

  // control registers
  logic [7:0] tctrl_r, gctrl_r, gsrc_r;
  logic [1:0] csrc_r;
  logic [15:0] count_r;
  logic ovf_r, wake_r;

  // count path state
  logic [1:0] instr_div_r;
  logic [2:0] ps_cnt_r;
  logic ext_s1_r, ext_s2_r, ext_sd_r, ext_a_r;
  logic c1_s1_r, c1_s2_r, c2_s1_r, c2_s2_r;
  logic t0_pulse_r, gate_val_r, armed_r, on_d_r;

  logic timer_on, unsync, gate_en, gate_pol;
  logic [1:0] ps_sel;
  logic [2:0] ps_mask;
  logic ext_rise, ext_fall, gate_lvl, gate_ok, run, tick, inc, cnt_wr;
  logic wr_low, wr_high, wr_stat;
  logic rollover;

  assign timer_on = tctrl_r[TIMER_ON_BIT];
  assign unsync = tctrl_r[UNSYNC_BIT];
  assign ps_sel = tctrl_r[PRESCALE_LSB +: 2];
  assign gate_en = gctrl_r[GATE_ENABLE_BIT];
  assign gate_pol = gctrl_r[GATE_POLARITY_BIT];

  // bus handshakes: address and data taken in either order, answer after both
  // the register effect and BVALID share one edge, one cycle after the later take;
  // a master that waits for BVALID therefore always reads back the new value
  assign aw_take = AWVALID && awready_r;
  assign w_take = WVALID && wready_r;
  assign ar_take = ARVALID && arready_r;
  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign aw_have_nxt = aw_take || (aw_have_r && !do_write);
  assign w_have_nxt = w_take || (w_have_r && !do_write);
  assign bvalid_nxt = do_write || (bvalid_r && !BREADY);
  assign rvalid_nxt = ar_take || (rvalid_r && !RREADY);
  // write decode uses the held address, read decode the live one
  assign wr_idx = reg_index(aw_addr_r);
  assign rd_idx = reg_index(ARADDR);
  // registers are one byte wide, so upper byte lanes are ignored
  assign wr_b0 = do_write && w_strb_r[0];
  assign wr_low = wr_b0 && (wr_idx == IDX_CLOW);
  assign wr_high = wr_b0 && (wr_idx == IDX_CHIGH);
  assign wr_stat = wr_b0 && (wr_idx == IDX_STAT);
  assign cnt_wr = wr_low || wr_high;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      // ready drops once a beat is held and returns only after the response is taken
      awready_r <= !aw_have_nxt && !bvalid_nxt;
      wready_r <= !w_have_nxt && !bvalid_nxt;
      arready_r <= !rvalid_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= AWADDR;
      end
      if (w_take) begin
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end
      // an unmapped write is answered with an error and changes nothing
      if (do_write) begin
        bresp_r <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // reads sample registers on the bus clock; the two count bytes are separate reads, so a 16-bit count can tear between them
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rresp_r <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      // fields above bit 7 read as zero
      case (rd_idx)
        IDX_TCTRL: rdata_r <= {24'h000000, tctrl_r};
        IDX_GCTRL: rdata_r <= {24'h000000, gctrl_r[7:3], gate_val_r, 2'h0};
        IDX_GSRC: rdata_r <= {24'h000000, gsrc_r};
        IDX_CSRC: rdata_r <= {30'h0, csrc_r};
        IDX_CLOW: rdata_r <= {24'h000000, count_r[7:0]};
        IDX_CHIGH: rdata_r <= {24'h000000, count_r[15:8]};
        IDX_STAT: rdata_r <= {31'h0, ovf_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers; only byte lane 0 carries data
  // masks keep unimplemented bits at zero so read-back matches the hardware
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tctrl_r <= TCTRL_RST;
      gctrl_r <= GCTRL_RST;
      gsrc_r <= GSRC_RST;
      csrc_r <= CSRC_RST;
    end else if (wr_b0) begin
      case (wr_idx)
        IDX_TCTRL: tctrl_r <= w_data_r[7:0] & 8'h35;
        IDX_GCTRL: gctrl_r <= w_data_r[7:0] & 8'hc0;
        IDX_GSRC: gsrc_r <= w_data_r[7:0] & 8'h37;
        IDX_CSRC: csrc_r <= w_data_r[1:0];
        default: ;
      endcase
    end
  end

  // synchronisers: first stage feeds only the second
  // the synchronised path costs three clocks of latency; the raw path costs one
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_sd_r <= 1'b0;
      ext_a_r <= 1'b0;
      c1_s1_r <= 1'b0;
      c1_s2_r <= 1'b0;
      c2_s1_r <= 1'b0;
      c2_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= EXT_COUNT_IN;
      ext_s2_r <= ext_s1_r;
      ext_sd_r <= ext_s2_r;
      ext_a_r <= EXT_COUNT_IN;
      c1_s1_r <= CMP1_OUT;
      c1_s2_r <= c1_s1_r;
      c2_s1_r <= CMP2_OUT;
      c2_s2_r <= c2_s1_r;
    end
  end

  // unsync mode bypasses the two-stage path; switching modes can drop or add an edge
  always_comb begin
    if (unsync) begin
      ext_rise = EXT_COUNT_IN && !ext_a_r;
      ext_fall = !EXT_COUNT_IN && ext_a_r;
    end else begin
      ext_rise = ext_s2_r && !ext_sd_r;
      ext_fall = !ext_s2_r && ext_sd_r;
    end
  end

  // gate source choice
  // unused source codes give a low gate, so polarity 0 then counts freely
  always_comb begin
    case (gsrc_r[2:0])
      GSRC_PIN: gate_lvl = GATE_PIN_IN;
      GSRC_T0: gate_lvl = t0_pulse_r;
      GSRC_CMP1: gate_lvl = gsrc_r[CMP1_SYNC_BIT] ? c1_s2_r : CMP1_OUT;
      GSRC_CMP2: gate_lvl = gsrc_r[CMP2_SYNC_BIT] ? c2_s2_r : CMP2_OUT;
      default: gate_lvl = 1'b0;
    endcase
  end

  // one-cycle high pulse per timer0 wrap
  // the pulse is one clock late, which only shifts the gated window
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      t0_pulse_r <= 1'b0;
      gate_val_r <= 1'b0;
    end else begin
      t0_pulse_r <= T0_MODE_8BIT ? T0_PERIOD_MATCH : T0_OVERFLOW;
      gate_val_r <= gate_lvl;
    end
  end

  // the registered gate level is also what software reads back
  assign gate_ok = !gate_en || (gate_val_r == gate_pol);
  // in sleep only the unsynchronised external counter keeps running
  // a synchronised counter stops in sleep, as its sampling clock would
  assign run = timer_on && gate_ok
    && (!SLEEP || (unsync && csrc_r == CSRC_EXT));

  // arming for counter mode: cleared on enable change or byte write, set by a fall
  // an input already high at enable is thus never mistaken for a rising edge
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      on_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      on_d_r <= timer_on;
      if (cnt_wr || (timer_on != on_d_r)) begin
        armed_r <= 1'b0;
      end else if (ext_fall) begin
        armed_r <= 1'b1;
      end
    end
  end

  // instruction cycle divider runs freely
  // writes do not realign it, so the first instruction tick after enable may come early
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      instr_div_r <= 2'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  always_comb begin
    // code 3 selects no source and gives no ticks
    case (csrc_r)
      CSRC_INSTR: tick = (instr_div_r == INSTR_LAST);
      CSRC_FULL: tick = 1'b1;
      CSRC_EXT: tick = ext_rise && armed_r;
      default: tick = 1'b0;
    endcase
  end

  // prescaler: 1,2,4,8 -> mask 0,1,3,7
  // the prescaler sits after the gate, so a closed gate also freezes its phase
  always_comb begin
    case (ps_sel)
      2'h0: ps_mask = 3'h0;
      2'h1: ps_mask = 3'h1;
      2'h2: ps_mask = 3'h3;
      default: ps_mask = 3'h7;
    endcase
  end

  assign inc = run && tick && ((ps_cnt_r & ps_mask) == ps_mask);

  // prescale counter has no register address
  // a held gate keeps the partial count, so the next window resumes mid-phase
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ps_cnt_r <= 3'h0;
    end else if (cnt_wr) begin
      ps_cnt_r <= 3'h0;
    end else if (run && tick) begin
      ps_cnt_r <= (ps_cnt_r + 3'h1) & ps_mask;
    end
  end

  // byte writes take precedence over a coincident increment
  // a write that lands on an increment loses that increment instead of tearing the count
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      count_r <= COUNT_RST;
    end else if (wr_low) begin
      count_r[7:0] <= w_data_r[7:0];
    end else if (wr_high) begin
      count_r[15:8] <= w_data_r[7:0];
    end else if (inc) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // one rollover event feeds both the sticky flag and the wake pulse
  assign rollover = inc && (count_r == 16'hffff);

  // overflow flag: write one to clear, a rollover in the same cycle wins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ovf_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      if (rollover) begin
        ovf_r <= 1'b1;
      end else if (wr_stat && w_data_r[OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
      wake_r <= SLEEP && rollover;
    end
  end

  // every output is a register, so nothing combinational reaches the pins
  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign OVERFLOW_FLAG = ovf_r;
  assign WAKE_REQ = wake_r;
  assign COUNT_VALUE = count_r;
endmodule : gated_sixteen_bit_timer

// ===== test/gtimer_properties.sv
// Purpose: port-level assertions for the gated timer
// Assumes: one clock, RST_B synchronous active low
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module gtimer_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [7:0] ARADDR,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  // timer
  input wire logic SLEEP,
  input wire logic OVERFLOW_FLAG,
  input wire logic WAKE_REQ,
  input wire logic [15:0] COUNT_VALUE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_WR_ANSWER: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write not answered");
  AST_WR_REFUSE: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  AST_RD_ANSWER: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered");
  AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  AST_UNMAPPED: assert property (ARVALID && ARREADY && ARADDR > 8'h18 |=>
    RRESP == 2'h2 && RDATA == 32'h0) else $error("unmapped read wrong");
  // only a step of one or a byte write may move the count
  AST_COUNT_STEP: assert property ($changed(COUNT_VALUE) && $past(RST_B) |->
    COUNT_VALUE == $past(COUNT_VALUE) + 16'h1 || $rose(BVALID))
    else $error("count jumped");
  AST_OVF_SET: assert property ($past(RST_B) && $past(COUNT_VALUE) == 16'hffff &&
    COUNT_VALUE == 16'h0 && !$rose(BVALID) |-> ##[0:1] OVERFLOW_FLAG)
    else $error("rollover without flag");
  AST_WAKE: assert property (WAKE_REQ |-> (SLEEP || $past(SLEEP)) ##1 !WAKE_REQ)
    else $error("wake pulse wrong");
  cover property (BVALID && BRESP == 2'h2);
  cover property (WAKE_REQ);
  cover property (OVERFLOW_FLAG && COUNT_VALUE == 16'h0);
endmodule : gtimer_properties

bind gated_sixteen_bit_timer gtimer_properties chk (.CLK(CLK), .RST_B(RST_B),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
  .RDATA(RDATA), .RRESP(RRESP), .SLEEP(SLEEP), .OVERFLOW_FLAG(OVERFLOW_FLAG),
  .WAKE_REQ(WAKE_REQ), .COUNT_VALUE(COUNT_VALUE));

// ===== test/count_source_model.sv
// Purpose: external count clock and gate sources
// Assumes: bench sets gate levels; send() is called right after a clock edge
// Notes: count clock idles low between bursts, so no stray edges
`timescale 1ns/1ps
module count_source_model (
  // clock
  input wire logic clk,
  // gate levels: pin, comparator 1, comparator 2
  input wire logic [2:0] levels,
  // sources
  output logic ext_count,
  output logic gate_pin,
  output logic cmp1,
  output logic cmp2,
  output logic t0_ovf
);
  logic [2:0] t0_div = 3'h0;
  initial ext_count = 1'b0;
  initial t0_ovf = 1'b0;
  assign gate_pin = levels[0];
  assign cmp1 = levels[1];
  assign cmp2 = levels[2];
  // one-cycle overflow pulse every eight clocks
  always @(posedge clk) begin
    t0_div <= t0_div + 3'h1;
    t0_ovf <= (t0_div == 3'h7);
  end
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge clk);
      ext_count <= 1'b1;
      repeat (3) @(posedge clk);
      ext_count <= 1'b0;
    end
  endtask : send
endmodule : count_source_model

// ===== test/test_gated_sixteen_bit_timer.sv
// Purpose: self-checking bench for the gated timer
// Assumes: 40 MHz clock, write address and data offered together
// Notes: rate checks use 64-cycle windows, exact for any tick phase
`timescale 1ns/1ps
module test_gated_sixteen_bit_timer;
  import gtimer_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic SLEEP = 1'b0, woke = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, OVERFLOW_FLAG, WAKE_REQ;
  logic ext_count, gate_pin, cmp1, cmp2, t0_ovf;
  logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA, v;
  logic [1:0] BRESP, RRESP;
  logic [15:0] COUNT_VALUE;
  logic [2:0] levels = 3'h7;
  logic t0_8bit = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) if (WAKE_REQ === 1'b1) woke <= 1'b1;
  gated_sixteen_bit_timer uut (.CLK(CLK), .RST_B(RST_B), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .EXT_COUNT_IN(ext_count), .GATE_PIN_IN(gate_pin),
    .T0_OVERFLOW(t0_ovf && !t0_8bit), .T0_PERIOD_MATCH(t0_ovf), .T0_MODE_8BIT(t0_8bit),
    .CMP1_OUT(cmp1), .CMP2_OUT(cmp2),
    .SLEEP(SLEEP), .OVERFLOW_FLAG(OVERFLOW_FLAG), .WAKE_REQ(WAKE_REQ),
    .COUNT_VALUE(COUNT_VALUE));
  count_source_model model (.clk(CLK), .levels(levels), .ext_count(ext_count),
    .gate_pin(gate_pin), .cmp1(cmp1), .cmp2(cmp2), .t0_ovf(t0_ovf));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 40) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 40);
    hang(n);
    BREADY <= 1'b0;
    chk({30'h0, BRESP}, {30'h0, er});
    @(posedge CLK);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 40);
    hang(n);
    RREADY <= 1'b0;
    v = RDATA;
    chk({30'h0, RRESP}, {30'h0, er});
    @(posedge CLK);
  endtask : rd
  // counts seen in a 64-cycle window after the setting settles
  task automatic meas(input logic [31:0] e);
    logic [15:0] a;
    repeat (4) @(posedge CLK);
    a = COUNT_VALUE;
    repeat (64) @(posedge CLK);
    chk({16'h0, COUNT_VALUE - a}, e);
  endtask : meas
  task automatic t_regs();
    rd(TIMER_CONTROL_OFS, RESP_OKAY);
    chk(v, {24'h0, TCTRL_RST});
    rd(COUNT_HIGH_OFS, RESP_OKAY);
    chk(v, 32'h0);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, RESP_SLVERR);
    chk(v, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_rates();
    wr(CLOCK_SOURCE_OFS, {30'h0, CSRC_FULL}, RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      wr(TIMER_CONTROL_OFS, 32'(1 | (p << PRESCALE_LSB)), RESP_OKAY);
      meas(32'(64 >> p));
    end
    wr(CLOCK_SOURCE_OFS, {30'h0, CSRC_INSTR}, RESP_OKAY);
    wr(TIMER_CONTROL_OFS, 32'h1, RESP_OKAY);
    meas(32'd16);
    wr(CLOCK_SOURCE_OFS, 32'h3, RESP_OKAY);
    meas(32'd0);
    wr(TIMER_CONTROL_OFS, 32'h0, RESP_OKAY);
    meas(32'd0);
    $display("test rates done");
  endtask : t_rates
  task automatic t_gate();
    wr(CLOCK_SOURCE_OFS, {30'h0, CSRC_FULL}, RESP_OKAY);
    wr(TIMER_CONTROL_OFS, 32'h1, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      for (int g = 0; g < 2; g++) begin
        t0_8bit <= (g == 1);
        wr(GATE_SOURCE_OFS, 32'(s | (g ? 8'h30 : 8'h00)), RESP_OKAY);
        wr(GATE_CONTROL_OFS, 32'(8'h80 | (g << GATE_POLARITY_BIT)), RESP_OKAY);
        meas((s == 1) ? (g ? 32'd8 : 32'd56) : (g ? 32'd64 : 32'd0));
      end
    end
    rd(GATE_CONTROL_OFS, RESP_OKAY);
    chk(v, 32'hc4);
    levels <= 3'h0;
    wr(GATE_SOURCE_OFS, {29'h0, GSRC_PIN}, RESP_OKAY);
    wr(GATE_CONTROL_OFS, 32'h80, RESP_OKAY);
    meas(32'd64);
    wr(GATE_CONTROL_OFS, 32'h40, RESP_OKAY);
    meas(32'd64);
    $display("test gate done");
  endtask : t_gate
  task automatic t_bytes();
    wr(GATE_CONTROL_OFS, 32'h0, RESP_OKAY);
    wr(TIMER_CONTROL_OFS, 32'h31, RESP_OKAY);
    wr(COUNT_LOW_OFS, 32'h10, RESP_OKAY);
    chk({24'h0, COUNT_VALUE[7:0]}, 32'h10);
    repeat (4) @(posedge CLK);
    chk({24'h0, COUNT_VALUE[7:0]}, 32'h10);
    wr(COUNT_HIGH_OFS, 32'hab, RESP_OKAY);
    rd(COUNT_HIGH_OFS, RESP_OKAY);
    chk(v, 32'hab);
    $display("test bytes done");
  endtask : t_bytes
  task automatic t_overflow();
    int n;
    n = 0;
    wr(TIMER_CONTROL_OFS, 32'h0, RESP_OKAY);
    wr(COUNT_LOW_OFS, 32'hff, RESP_OKAY);
    wr(COUNT_HIGH_OFS, 32'hff, RESP_OKAY);
    wr(STATUS_OFS, 32'h1, RESP_OKAY);
    wr(TIMER_CONTROL_OFS, 32'h1, RESP_OKAY);
    while (COUNT_VALUE >= 16'hff00 && n < 40) begin
      @(posedge CLK);
      n++;
    end
    hang(n);
    chk({31'h0, OVERFLOW_FLAG}, 32'h1);
    wr(TIMER_CONTROL_OFS, 32'h0, RESP_OKAY);
    rd(STATUS_OFS, RESP_OKAY);
    chk(v, 32'h1);
    wr(STATUS_OFS, 32'h1, RESP_OKAY);
    rd(STATUS_OFS, RESP_OKAY);
    chk(v, 32'h0);
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_sleep();
    wr(CLOCK_SOURCE_OFS, {30'h0, CSRC_EXT}, RESP_OKAY);
    wr(COUNT_LOW_OFS, 32'hff, RESP_OKAY);
    wr(COUNT_HIGH_OFS, 32'hff, RESP_OKAY);
    wr(TIMER_CONTROL_OFS, 32'h5, RESP_OKAY);
    SLEEP <= 1'b1;
    woke <= 1'b0;
    model.send(2);
    repeat (6) @(posedge CLK);
    chk({16'h0, COUNT_VALUE}, 32'h0);
    chk({31'h0, woke}, 32'h1);
    SLEEP <= 1'b0;
    model.send(1);
    repeat (6) @(posedge CLK);
    chk({16'h0, COUNT_VALUE}, 32'h1);
    wr(TIMER_CONTROL_OFS, 32'h1, RESP_OKAY);
    model.send(1);
    repeat (6) @(posedge CLK);
    chk({16'h0, COUNT_VALUE}, 32'h2);
    $display("test sleep done");
  endtask : t_sleep
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    t_regs();
    t_rates();
    t_gate();
    t_bytes();
    t_overflow();
    t_sleep();
    finish_test();
  end
endmodule : test_gated_sixteen_bit_timer
